// ---- rtl/evsys_router.sv ----
/*
  Event channel routing matrix: twelve channels, forty-seven consumers.
  Assumes generator levels on the link are synchronous to clk_in and
  that gen bit 0 is held low by the peer.
*/
`timescale 1ns/1ps
`default_nettype none
module evsys_router (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sleep_in,
  output logic [11:0] clk_req_out,
  evsys_link_if.router link
);
  // ----------------------------------------
  // Configuration storage
  // ----------------------------------------
  logic [31:0] cfg [evsys_pkg::NUM_CH];
  logic [31:0] user_sel [evsys_pkg::NUM_USER];
  logic [31:0] next_rdata;
  logic [11:0] ch_sig;
  logic [11:0] ch_async;
  logic [11:0] evt;

  genvar n;
  generate
    for (n = 0; n < evsys_pkg::NUM_CH; n++) begin : g_cfg
      localparam logic [11:0] ADR = 12'(evsys_pkg::CH_BASE +
        12'(n) * evsys_pkg::REG_STRIDE);
      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          cfg[n] <= evsys_pkg::CFG_RESET;
        end else if (link.wr && link.addr == ADR) begin
          cfg[n] <= link.wdata & evsys_pkg::CFG_MASK;
        end
      end
    end
    for (n = 0; n < evsys_pkg::NUM_USER; n++) begin : g_usr
      localparam logic [11:0] ADR = 12'(evsys_pkg::USER_BASE +
        12'(n) * evsys_pkg::REG_STRIDE);
      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          user_sel[n] <= evsys_pkg::USER_RESET;
        end else if (link.wr && link.addr == ADR) begin
          user_sel[n] <= link.wdata & evsys_pkg::USER_MASK;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < evsys_pkg::NUM_CH; i++) begin
      if (link.addr == 12'(evsys_pkg::CH_BASE +
          12'(i) * evsys_pkg::REG_STRIDE)) begin
        next_rdata = cfg[i];
      end
    end
    for (int i = 0; i < evsys_pkg::NUM_USER; i++) begin
      if (link.addr == 12'(evsys_pkg::USER_BASE +
          12'(i) * evsys_pkg::REG_STRIDE)) begin
        next_rdata = user_sel[i];
      end
    end
  end

  // Unmapped reads answer zero; data stands one cycle only
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      link.rdata <= 32'h0000_0000;
    end else if (link.rd) begin
      link.rdata <= next_rdata;
    end else begin
      link.rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  generate
    for (n = 0; n < evsys_pkg::NUM_CH; n++) begin : g_ch
      logic [7:0] src;
      evsys_pkg::path_t path;
      evsys_pkg::edge_t edg;
      logic keep;
      logic ondem;
      logic active;
      logic src_ok;
      logic gen_lvl;
      logic stage1;
      logic stage2;
      logic prev;
      logic seen;
      logic rise;
      logic fall;

      assign src = cfg[n][evsys_pkg::SRC_LSB +: 8];
      assign path = evsys_pkg::path_t'(cfg[n][evsys_pkg::PATH_LSB +: 2]);
      assign edg = evsys_pkg::edge_t'(cfg[n][evsys_pkg::EDGE_LSB +: 2]);
      assign keep = cfg[n][evsys_pkg::KEEP_BIT];
      assign ondem = cfg[n][evsys_pkg::ONDEM_BIT];
      assign active = !sleep_in || keep;
      // Reserved source codes act as no source
      assign src_ok = src != evsys_pkg::SRC_NONE &&
        src <= evsys_pkg::SRC_LAST;
      assign gen_lvl = src_ok && link.gen[src[6:0]];

      // Resync adds a stage; costs a cycle of latency
      assign seen = (path == evsys_pkg::PATH_RESYNC) ? stage2 : stage1;
      assign rise = seen && !prev;
      assign fall = !seen && prev;

      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          prev <= 1'b0;
        end else begin
          stage1 <= active && gen_lvl;
          stage2 <= stage1;
          prev <= seen;
        end
      end

      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          evt[n] <= 1'b0;
        end else begin
          unique case (path)
            evsys_pkg::PATH_SYNC,
            evsys_pkg::PATH_RESYNC: begin
              evt[n] <= active && (
                (edg[0] && rise) || (edg[1] && fall));
            end
            evsys_pkg::PATH_ASYNC,
            evsys_pkg::PATH_RSVD: begin
              evt[n] <= 1'b0;
            end
          endcase
        end
      end

      // Async path forwards the level with no edge logic
      assign ch_async[n] = path == evsys_pkg::PATH_ASYNC;
      assign ch_sig[n] = ch_async[n] ? (active && gen_lvl) : evt[n];

      // Always-on keeps the clock while configured and active
      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          clk_req_out[n] <= 1'b0;
        end else begin
          clk_req_out[n] <= active && src_ok &&
            path != evsys_pkg::PATH_RSVD &&
            (!ondem || stage1 || seen || evt[n]);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Consumers
  // ----------------------------------------
  generate
    for (n = 0; n < evsys_pkg::NUM_USER; n++) begin : g_user
      logic [7:0] sel;
      logic [3:0] ch;
      logic hit;
      logic allowed;

      assign sel = user_sel[n][7:0];
      assign hit = sel != evsys_pkg::SEL_NONE &&
        sel <= evsys_pkg::SEL_LAST;
      assign ch = 4'(sel - 8'h01);
      if (n <= evsys_pkg::FULL_PATH_LAST_USER) begin : g_any
        assign allowed = 1'b1;
      end else if (n <= evsys_pkg::ASYNC_LAST_USER) begin : g_async
        assign allowed = ch_async[ch];
      end else begin : g_rsvd
        assign allowed = 1'b0;
      end

      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          link.user_evt[n] <= 1'b0;
        end else begin
          link.user_evt[n] <= hit && allowed && ch_sig[ch];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/evsys_pkg.sv ----
/*
  Shared constants and types for the event routing matrix and its peer.
  Assumes one 20 MHz clock and synchronous, active-low reset at both ends.
*/
package evsys_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CH = 12;
  localparam int NUM_USER = 47;
  localparam int NUM_GEN = 87;
  localparam int ADDR_W = 12;
  localparam int FULL_PATH_LAST_USER = 27;
  localparam int ASYNC_LAST_USER = 43;
  localparam int CLK_PERIOD_NS = 50;

  // ----------------------------------------
  // Device register map
  // ----------------------------------------
  localparam logic [11:0] CH_BASE = 12'h020;
  localparam logic [11:0] USER_BASE = 12'h080;
  localparam logic [11:0] REG_STRIDE = 12'h004;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] USER_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK = 32'h0000_CFFF;
  localparam logic [31:0] USER_MASK = 32'h0000_00FF;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SRC_LSB = 0;
  localparam int PATH_LSB = 8;
  localparam int EDGE_LSB = 10;
  localparam int KEEP_BIT = 14;
  localparam int ONDEM_BIT = 15;
  localparam logic [7:0] SRC_NONE = 8'h00;
  localparam logic [7:0] SRC_LAST = 8'h56;
  localparam logic [7:0] SEL_NONE = 8'h00;
  localparam logic [7:0] SEL_LAST = 8'h0C;

  typedef enum logic [1:0] {
    PATH_SYNC = 2'b00,
    PATH_RESYNC = 2'b01,
    PATH_ASYNC = 2'b10,
    PATH_RSVD = 2'b11
  } path_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_t;

  // ----------------------------------------
  // Peer controller register map
  // ----------------------------------------
  localparam logic [7:0] P_TARGET = 8'h00;
  localparam logic [7:0] P_DATA = 8'h04;
  localparam logic [7:0] P_CMD = 8'h08;
  localparam logic [7:0] P_RESULT = 8'h0C;
  localparam logic [7:0] P_GEN0 = 8'h10;
  localparam logic [7:0] P_GEN1 = 8'h14;
  localparam logic [7:0] P_GEN2 = 8'h18;
  localparam logic [7:0] P_SEEN0 = 8'h1C;
  localparam logic [7:0] P_SEEN1 = 8'h20;
  localparam logic [7:0] P_STATUS = 8'h24;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;

  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_WRITE = 2'b01,
    PS_READ = 2'b10,
    PS_CATCH = 2'b11
  } peer_state_t;
endpackage

// ---- rtl/evsys_link_if.sv ----
/*
  Link between the routing matrix and the peripheral peer.
  Assumes both ends share clk_in; no clocking block.
*/
`timescale 1ns/1ps
`default_nettype none
interface evsys_link_if;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [86:0] gen;
  logic [46:0] user_evt;

  modport router (
    input addr, wdata, wr, rd, gen,
    output rdata, user_evt
  );
  modport peer (
    output addr, wdata, wr, rd, gen,
    input rdata, user_evt
  );
endinterface
`default_nettype wire

// ---- rtl/evsys_peer.sv ----
/*
  Peripheral-side peer: drives generator levels, watches consumer
  events and performs register accesses on the router for software.
  Assumes a plain software port with one-cycle read latency.
*/
`timescale 1ns/1ps
`default_nettype none
module evsys_peer (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  evsys_link_if.peer link
);
  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [11:0] target;
  logic [31:0] data;
  logic [31:0] result;
  logic [95:0] gen_drive;
  logic [63:0] seen;
  logic [31:0] wr_data_fix;
  logic [31:0] next_rdata;
  logic catch_d;
  evsys_pkg::peer_state_t state;

  // Edge bits cleared whenever the async path is written
  always_comb begin
    wr_data_fix = data;
    if (target >= evsys_pkg::CH_BASE && target < evsys_pkg::USER_BASE &&
        data[evsys_pkg::PATH_LSB +: 2] == evsys_pkg::PATH_ASYNC) begin
      wr_data_fix[evsys_pkg::EDGE_LSB +: 2] = evsys_pkg::EDGE_NONE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      target <= 12'h000;
      data <= 32'h0000_0000;
      gen_drive <= 96'h0;
    end else if (wr_in) begin
      if (addr_in == evsys_pkg::P_TARGET) target <= wdata_in[11:0];
      if (addr_in == evsys_pkg::P_DATA) data <= wdata_in;
      if (addr_in == evsys_pkg::P_GEN0) gen_drive[31:0] <= wdata_in;
      if (addr_in == evsys_pkg::P_GEN1) gen_drive[63:32] <= wdata_in;
      if (addr_in == evsys_pkg::P_GEN2) gen_drive[95:64] <= wdata_in;
    end
  end

  // Bit 0 is the no-source slot and stays low
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      link.gen <= 87'h0;
    end else begin
      link.gen <= {gen_drive[86:1], 1'b0};
    end
  end

  // Sticky event capture; a new event beats the clear
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      seen <= 64'h0;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (wr_in && addr_in == evsys_pkg::P_SEEN0 && wdata_in[i]) begin
          seen[i] <= 1'b0;
        end
        if (wr_in && addr_in == evsys_pkg::P_SEEN1 && wdata_in[i]) begin
          seen[32 + i] <= 1'b0;
        end
      end
      // Reserved consumers above 43 are never recorded
      for (int i = 0; i <= evsys_pkg::ASYNC_LAST_USER; i++) begin
        if (link.user_evt[i]) seen[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= evsys_pkg::PS_IDLE;
    end else begin
      unique case (state)
        evsys_pkg::PS_IDLE: begin
          if (wr_in && addr_in == evsys_pkg::P_CMD) begin
            if (wdata_in[1:0] == evsys_pkg::CMD_WRITE) begin
              state <= evsys_pkg::PS_WRITE;
            end else if (wdata_in[1:0] == evsys_pkg::CMD_READ) begin
              state <= evsys_pkg::PS_READ;
            end
          end
        end
        evsys_pkg::PS_WRITE: state <= evsys_pkg::PS_IDLE;
        evsys_pkg::PS_READ: state <= evsys_pkg::PS_CATCH;
        evsys_pkg::PS_CATCH: state <= evsys_pkg::PS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      link.addr <= 12'h000;
      link.wdata <= 32'h0000_0000;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
    end else begin
      link.addr <= target;
      link.wdata <= wr_data_fix;
      link.wr <= state == evsys_pkg::PS_WRITE;
      link.rd <= state == evsys_pkg::PS_READ;
    end
  end

  // Link strobes lag the state by one flop stage
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      catch_d <= 1'b0;
    end else begin
      catch_d <= link.rd;
    end
  end

  // Latch in the cycle the link data stands, not on the state
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      result <= 32'h0000_0000;
    end else if (catch_d) begin
      result <= link.rdata;
    end
  end

  // ----------------------------------------
  // Software read port
  // ----------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr_in)
      evsys_pkg::P_TARGET: next_rdata = {20'h0, target};
      evsys_pkg::P_DATA: next_rdata = data;
      evsys_pkg::P_RESULT: next_rdata = catch_d ? link.rdata : result;
      evsys_pkg::P_GEN0: next_rdata = gen_drive[31:0];
      evsys_pkg::P_GEN1: next_rdata = gen_drive[63:32];
      evsys_pkg::P_GEN2: next_rdata = gen_drive[95:64];
      evsys_pkg::P_SEEN0: next_rdata = seen[31:0];
      evsys_pkg::P_SEEN1: next_rdata = seen[63:32];
      evsys_pkg::P_STATUS: next_rdata = {31'h0, state != evsys_pkg::PS_IDLE};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/evsys_link_props.sv ----
/*
  Checker on the link between router and peer, channel 0 and consumer 0.
  Assumes one clock, synchronous active-low reset, link signals as inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module evsys_link_props (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic sleep_in,
  input wire logic [11:0] clk_req_out,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [86:0] gen,
  input wire logic [46:0] user_evt
);
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  logic [31:0] cfg0;
  logic [7:0] sel0;
  logic [3:0] quiet;
  logic sleep_q;
  logic src_ok;
  logic live;
  // Long quiet span so no event of an old setting is still in flight
  assign src_ok = cfg0[7:0] != 8'h00 && cfg0[7:0] <= 8'h56;
  assign live = quiet == 4'hF && (!sleep_in || cfg0[14]);
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cfg0 <= 32'h0000_0000;
    end else if (wr && addr == 12'h020) begin
      cfg0 <= wdata;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      sel0 <= 8'h00;
    end else if (wr && addr == 12'h080) begin
      sel0 <= wdata[7:0];
    end
  end
  always_ff @(posedge clk_in) begin
    sleep_q <= sleep_in;
    if (!nrst_in || wr || sleep_q != sleep_in) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  property p_unmapped_read;
    rd && !((addr >= 12'h020 && addr < 12'h050 || addr >= 12'h080 &&
      addr < 12'h13C) && addr[1:0] == 2'b00) |=> rdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned data");
  property p_gen_none;
    gen[0] == 1'b0;
  endproperty
  a_gen_none: assert property (p_gen_none)
    else $error("source code zero carries a level");
  property p_rsvd_users;
    user_evt[46:44] == 3'b000;
  endproperty
  a_rsvd_users: assert property (p_rsvd_users)
    else $error("reserved consumer got an event");
  property p_edge_none;
    live && sel0 == 8'h01 && !cfg0[9] && cfg0[11:10] == 2'b00 |-> !user_evt[0];
  endproperty
  a_edge_none: assert property (p_edge_none)
    else $error("event with edge detection off");
  property p_path_rsvd;
    quiet == 4'hF && sel0 == 8'h01 && cfg0[9:8] == 2'b11 |-> !user_evt[0];
  endproperty
  a_path_rsvd: assert property (p_path_rsvd)
    else $error("event on reserved path");
  property p_sel_rsvd;
    quiet == 4'hF && (sel0 == 8'h00 || sel0 > 8'h0C) |-> user_evt[0] == 1'b0;
  endproperty
  a_sel_rsvd: assert property (p_sel_rsvd)
    else $error("unconnected consumer got an event");
  property p_async;
    live && sel0 == 8'h01 && cfg0[9:8] == 2'b10 && src_ok |->
      user_evt[0] == $past(gen[cfg0[7:0]]);
  endproperty
  a_async: assert property (p_async)
    else $error("async consumer does not follow level");
  property p_rise;
    live && sel0 == 8'h01 && !cfg0[9] && cfg0[10] && src_ok &&
      $rose(gen[cfg0[7:0]]) |-> ##[1:5] user_evt[0];
  endproperty
  a_rise: assert property (p_rise)
    else $error("rising edge gave no event");
  property p_sleep;
    quiet == 4'hF && sleep_in && !cfg0[14] |-> clk_req_out[0] == 1'b0;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleeping channel requests clock");
endmodule
`default_nettype wire

// ---- testbench/evsys_router_tb.sv ----
/*
  Self-checking bench: router and peer joined by the link interface.
  Assumes the peer software port with one-cycle read latency.
*/
`timescale 1ns/1ps
`default_nettype none
module evsys_router_tb;
  logic clk_in;
  logic nrst_in = 1'b0;
  logic sleep_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic [11:0] clk_req_out;
  logic prev_evt = 1'b0;
  int miscompares = 0;
  int num_checks = 0;
  int ev_cnt = 0;
  int tm = 0;
  evsys_link_if link ();
  evsys_router i_evsys_router (.clk_in(clk_in), .nrst_in(nrst_in),
    .sleep_in(sleep_in), .clk_req_out(clk_req_out), .link(link));
  evsys_peer i_evsys_peer (.clk_in(clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .link(link));
  evsys_link_props i_evsys_link_props (.clk_in(clk_in), .nrst_in(nrst_in),
    .sleep_in(sleep_in), .clk_req_out(clk_req_out), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .gen(link.gen), .user_evt(link.user_evt));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Rising edges on the watched consumer line
  always @(posedge clk_in) begin
    if (link.user_evt[tm] === 1'b1 && prev_evt !== 1'b1) ev_cnt++;
    prev_evt = link.user_evt[tm];
  end
  task automatic report(input string msg);
    miscompares++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) report($sformatf("reg %h expected %h", got, exp));
  endtask
  task automatic chk_cnt(input int got, input int exp);
    num_checks++;
    if (got != exp) report($sformatf("events %0d expected %0d", got, exp));
  endtask
  task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    d = rdata_out;
  endtask
  task automatic wait_idle();
    logic [31:0] s;
    s = 32'h0000_0001;
    for (int k = 0; k < 20 && s[0] !== 1'b0; k++) sw_rd(evsys_pkg::P_STATUS, s);
    if (s[0] !== 1'b0) report("peer stays busy");
  endtask
  task automatic dev_wr(input logic [11:0] a, input logic [31:0] d);
    sw_wr(evsys_pkg::P_TARGET, {20'h00000, a});
    sw_wr(evsys_pkg::P_DATA, d);
    sw_wr(evsys_pkg::P_CMD, {30'h00000000, evsys_pkg::CMD_WRITE});
    wait_idle();
  endtask
  task automatic dev_rd(input logic [11:0] a, output logic [31:0] d);
    sw_wr(evsys_pkg::P_TARGET, {20'h00000, a});
    sw_wr(evsys_pkg::P_CMD, {30'h00000000, evsys_pkg::CMD_READ});
    wait_idle();
    sw_rd(evsys_pkg::P_RESULT, d);
  endtask
  // Events expected at consumer m for one rise and one fall of source g;
  // mc holds every channel setting as last written
  function automatic int exp_evt(input logic [31:0] mc [12], int g, int sel,
      int m, int sl);
    int p;
    int e;
    if (sel == 0 || sel > 12 || m > 43) return 0;
    if (mc[sel - 1][7:0] != g) return 0;
    p = mc[sel - 1][9:8];
    e = mc[sel - 1][11:10];
    if (p == 3 || (sl != 0 && !mc[sel - 1][14])) return 0;
    if (m > 27 && p != 2) return 0;
    if (p == 2) return 1;
    return e % 2 + e / 2;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(50 * 40000);
    report("timeout");
    complete_run();
  end
  initial begin
    int p, e, n, m, s, g, sel, sl, kp, od, c0, ec;
    logic [31:0] d, cfg, ucfg;
    logic [31:0] mc [12];
    logic [7:0] ga;
    logic rq;
    void'($urandom(32'h3F60F0BC));
    for (int k = 0; k < 12; k++) mc[k] = evsys_pkg::CFG_RESET;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    dev_rd(12'h020, d);
    chk_reg(d, evsys_pkg::CFG_RESET);
    dev_rd(12'h138, d);
    chk_reg(d, evsys_pkg::USER_RESET);
    $display("reset values done");
    dev_wr(12'h200, 32'hFFFF_FFFF);
    dev_rd(12'h200, d);
    chk_reg(d, 32'h0000_0000);
    sw_rd(8'h40, d);
    chk_reg(d, 32'h0000_0000);
    $display("unmapped access done");
    for (int i = 0; i < 24; i++) begin
      p = i % 4;
      e = (i < 16) ? i / 4 : $urandom % 4;
      n = (i < 8) ? 0 : $urandom % 12;
      m = (i < 8) ? 0 : $urandom % 47;
      s = (i < 16) ? 1 + $urandom % 86 : $urandom % 256;
      g = (s >= 1 && s <= 86) ? s : 1 + $urandom % 86;
      sel = (i < 20) ? n + 1 : $urandom % 16;
      sl = (i >= 8) ? $urandom % 2 : 0;
      kp = $urandom % 2;
      od = $urandom % 2;
      sleep_in <= sl[0];
      cfg = {16'hA5A5, od[0], kp[0], 2'b11, e[1:0], p[1:0], s[7:0]};
      ucfg = {24'h5A5A5A, sel[7:0]};
      dev_wr(12'h020 + 12'(4 * n), cfg);
      dev_wr(12'h080 + 12'(4 * m), ucfg);
      dev_rd(12'h020 + 12'(4 * n), d);
      if (p == 2) cfg[11:10] = 2'b00;
      chk_reg(d, cfg & evsys_pkg::CFG_MASK);
      mc[n] = cfg & evsys_pkg::CFG_MASK;
      dev_rd(12'h080 + 12'(4 * m), d);
      chk_reg(d, ucfg & evsys_pkg::USER_MASK);
      tm = m;
      sw_wr(evsys_pkg::P_SEEN0, 32'hFFFF_FFFF);
      sw_wr(evsys_pkg::P_SEEN1, 32'hFFFF_FFFF);
      c0 = ev_cnt;
      ga = evsys_pkg::P_GEN0 + 8'(4 * (g / 32));
      sw_wr(ga, 32'h0000_0001 << (g % 32));
      repeat (8) @(posedge clk_in);
      sw_wr(ga, 32'h0000_0000);
      repeat (8) @(posedge clk_in);
      ec = exp_evt(mc, g, sel, m, sl);
      chk_cnt(ev_cnt - c0, ec);
      // Sticky seen bit set exactly when any event is expected
      sw_rd(evsys_pkg::P_SEEN0 + 8'(4 * (m / 32)), d);
      chk_reg({31'h0, d[m % 32]}, {31'h0, ec > 0});
      rq = (sl == 0 || kp != 0) && s >= 1 && s <= 86 && p != 3 && od == 0;
      chk_reg({31'h0, clk_req_out[n]}, {31'h0, rq});
      $display("trial %0d done", i);
    end
    complete_run();
  end
endmodule
`default_nettype wire
